// *** core/aad_datapath.sv ***
// Accumulator datapath: add and AND of the accumulator with a file register
// or an immediate, with destination select and C/DC/Z flags.
// Assumes the register file answers rf_raddr_o combinationally on rf_rdata_i
// in the same cycle, and the decoder holds its fields for the valid cycle.
// No forwarding: the write-back pulse lands one cycle after the op, so a
// read of the same register by the very next op sees the old value unless
// the register file forwards or the decoder leaves a gap.
//
// How it works
// - add immediate into accumulator, flags, one cycle
// - add register, flags, d=0 to accumulator
// - add register with d=1 writes file register
// - AND register updates only zero flag
// - AND register d selects accumulator or register
// - AND immediate leaves result in accumulator
`timescale 1ns/10ps
module aad_datapath (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             srst_i,
    // Instruction decoder
    input  wire logic             op_valid_i,
    input  wire aad_pkg::aad_op_t opcode_i,
    input  wire logic [7:0]       imm_i,
    input  wire logic [5:0]       reg_addr_i,
    input  wire logic             dest_i,
    // Register file
    output logic      [5:0]       rf_raddr_o,
    input  wire logic [7:0]       rf_rdata_i,
    output logic                  rf_we_o,
    output logic      [5:0]       rf_waddr_o,
    output logic      [7:0]       rf_wdata_o,
    // Architectural state
    output logic      [7:0]       accumulator_o,
    output logic                  carry_flag_o,
    output logic                  digit_carry_flag_o,
    output logic                  zero_flag_o
);

    aad_alu_if alu_bus ();

    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic       c_r;
    logic       c_nxt;
    logic       dc_r;
    logic       dc_nxt;
    logic       z_r;
    logic       z_nxt;
    logic       we_r;
    logic       we_nxt;
    logic [5:0] waddr_r;
    logic [5:0] waddr_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;

    logic       is_reg_op_w;
    logic       is_add_w;
    logic       to_file_w;
    logic       to_acc_w;

    // Operation decode
    assign is_reg_op_w = (opcode_i == aad_pkg::AAD_OP_ADD_REG)
                      || (opcode_i == aad_pkg::AAD_OP_AND_REG);
    assign is_add_w    = (opcode_i == aad_pkg::AAD_OP_ADD_REG)
                      || (opcode_i == aad_pkg::AAD_OP_ADD_IMM);
    // Immediate forms ignore dest_i so they can never write the file
    assign to_file_w   = op_valid_i && is_reg_op_w && dest_i;
    assign to_acc_w    = op_valid_i && !to_file_w;

    // ALU operands: accumulator against register data or immediate
    assign alu_bus.op  = opcode_i;
    assign alu_bus.a   = acc_r;
    assign alu_bus.b   = is_reg_op_w ? rf_rdata_i : imm_i;
    assign rf_raddr_o  = reg_addr_i;

    // One combinational ALU shared by all four ops
    aad_alu u_alu (
        .alu (alu_bus.alu)
    );

    // Next-state selection; every op retires in the cycle it is valid
    // AND ops leave C and DC alone; Z follows every result, AND included
    assign acc_nxt   = to_acc_w ? alu_bus.res : acc_r;
    assign c_nxt     = (op_valid_i && is_add_w) ? alu_bus.carry : c_r;
    assign dc_nxt    = (op_valid_i && is_add_w) ? alu_bus.digit_carry : dc_r;
    assign z_nxt     = op_valid_i ? alu_bus.zero : z_r;
    assign we_nxt    = to_file_w;
    assign waddr_nxt = to_file_w ? reg_addr_i : waddr_r;
    assign wdata_nxt = to_file_w ? alu_bus.res : wdata_r;

    // State registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            acc_r   <= aad_pkg::ACC_RST;
            c_r     <= aad_pkg::FLAG_RST;
            dc_r    <= aad_pkg::FLAG_RST;
            z_r     <= aad_pkg::FLAG_RST;
        end else begin
            acc_r   <= acc_nxt;
            c_r     <= c_nxt;
            dc_r    <= dc_nxt;
            z_r     <= z_nxt;
        end
    end

    // Write-back port; data and address hold between writes to ease debug
    // Registered so the file sees a clean one-cycle pulse, at one cycle of latency
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            we_r    <= 1'b0;
            waddr_r <= aad_pkg::ADDR_RST;
            wdata_r <= aad_pkg::WDATA_RST;
        end else begin
            we_r    <= we_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // Outputs other than rf_raddr_o come straight from flops; rf_raddr_o passes reg_addr_i straight through
    assign accumulator_o      = acc_r;
    assign carry_flag_o       = c_r;
    assign digit_carry_flag_o = dc_r;
    assign zero_flag_o        = z_r;
    assign rf_we_o            = we_r;
    assign rf_waddr_o         = waddr_r;
    assign rf_wdata_o         = wdata_r;

    // Checking helpers: reference sums built independently of the ALU
    // A fault in the shared ALU cannot hide behind its own expressions here
    logic [8:0] chk_sum_w;
    logic [4:0] chk_low_w;
    logic [7:0] chk_opnd_w;
    logic [7:0] chk_and_w;

    assign chk_opnd_w = is_reg_op_w ? rf_rdata_i : imm_i;
    assign chk_sum_w  = {1'b0, acc_r} + {1'b0, chk_opnd_w};
    assign chk_low_w  = {1'b0, acc_r[3:0]} + {1'b0, chk_opnd_w[3:0]};
    assign chk_and_w  = acc_r & chk_opnd_w;

    // All checks run on the core clock and sleep through reset
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    // One sequence per kind of take; the take checks other than a_andreg_only_z and a_andimm_acc_res are built from these
    sequence s_take_add_imm;
        op_valid_i && opcode_i == aad_pkg::AAD_OP_ADD_IMM;
    endsequence
    sequence s_take_add_reg(logic d);
        op_valid_i && opcode_i == aad_pkg::AAD_OP_ADD_REG && dest_i == d;
    endsequence
    sequence s_take_and_reg(logic d);
        op_valid_i && opcode_i == aad_pkg::AAD_OP_AND_REG && dest_i == d;
    endsequence
    sequence s_take_add;
        op_valid_i && (opcode_i == aad_pkg::AAD_OP_ADD_IMM
                    || opcode_i == aad_pkg::AAD_OP_ADD_REG);
    endsequence
    sequence s_take_and_imm;
        op_valid_i && opcode_i == aad_pkg::AAD_OP_AND_IMM;
    endsequence

    a_addimm_acc_sum: assert property (
        s_take_add_imm |=> accumulator_o == $past(chk_sum_w[7:0]) && !rf_we_o)
        else $error("add immediate did not land in accumulator");

    a_addreg_acc_dest: assert property (
        s_take_add_reg(1'b0) |=> accumulator_o == $past(chk_sum_w[7:0]) && !rf_we_o)
        else $error("add register d=0 result wrong");

    a_addreg_file_wb: assert property (
        s_take_add_reg(1'b1) |=> rf_we_o && rf_waddr_o == $past(reg_addr_i)
            && rf_wdata_o == $past(chk_sum_w[7:0]) && $stable(accumulator_o))
        else $error("add register d=1 write-back wrong");

    a_andreg_only_z: assert property (
        op_valid_i && opcode_i == aad_pkg::AAD_OP_AND_REG |=> $stable(carry_flag_o)
            && $stable(digit_carry_flag_o) && zero_flag_o == ($past(chk_and_w) == 8'h00))
        else $error("and register touched wrong flags");

    a_andreg_dest_sel: assert property (
        s_take_and_reg(1'b1) |=> rf_we_o && rf_wdata_o == $past(chk_and_w)
            && $stable(accumulator_o) ##1 !rf_we_o || $past(to_file_w))
        else $error("and register d=1 routing wrong");

    a_andimm_acc_res: assert property (
        op_valid_i && opcode_i == aad_pkg::AAD_OP_AND_IMM |=> accumulator_o
            == $past(chk_and_w) && !rf_we_o)
        else $error("and immediate result wrong");

    a_add_carry_out: assert property (
        s_take_add |=> carry_flag_o == $past(chk_sum_w[8])
            && zero_flag_o == ($past(chk_sum_w[7:0]) == 8'h00))
        else $error("add carry or zero flag wrong");

    a_add_digit_cy: assert property (
        s_take_add |=> digit_carry_flag_o == $past(chk_low_w[4]))
        else $error("add digit carry wrong");

    // Routing and flag checks for the forms not covered above
    a_andreg_acc_dest: assert property (
        s_take_and_reg(1'b0) |=> accumulator_o == $past(chk_and_w)
            && !rf_we_o && $stable(rf_wdata_o))
        else $error("and register d=0 routing wrong");

    a_andimm_keeps_cy: assert property (
        s_take_and_imm |=> $stable(carry_flag_o) && $stable(digit_carry_flag_o)
            && zero_flag_o == ($past(chk_and_w) == 8'h00))
        else $error("and immediate touched carry flags");

    // Hold checks: idle cycles must not disturb state, nor non-writing ops the write-back port
    a_idle_holds_state: assert property (
        !op_valid_i |=> $stable(accumulator_o) && $stable(carry_flag_o)
            && $stable(digit_carry_flag_o) && $stable(zero_flag_o)
            && !rf_we_o)
        else $error("idle cycle changed state");

    a_wb_port_holds: assert property (
        !to_file_w |=> !rf_we_o && $stable(rf_waddr_o)
            && $stable(rf_wdata_o))
        else $error("write-back port moved without a write");

endmodule // aad_datapath

// *** shared/aad_pkg.sv ***
// Shared constants and types for the accumulator add/AND datapath.
// Assumes one core clock and a synchronous active-high reset.
package aad_pkg;

    // Datapath and file address widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;

    // Reset values
    localparam logic [7:0] ACC_RST   = 8'h00;
    localparam logic       FLAG_RST  = 1'b0;
    localparam logic [7:0] WDATA_RST = 8'h00;
    localparam logic [5:0] ADDR_RST  = 6'h00;

    // Carry chain tap positions
    localparam int CARRY_BIT  = 8;
    localparam int DIGIT_BIT  = 4;

    // Operation codes from the instruction decoder
    typedef enum logic [1:0] {
        AAD_OP_ADD_REG = 2'h0,
        AAD_OP_ADD_IMM = 2'h1,
        AAD_OP_AND_REG = 2'h2,
        AAD_OP_AND_IMM = 2'h3
    } aad_op_t;

endpackage

// *** shared/aad_alu_if.sv ***
// Carrier between the datapath control and its combinational ALU.
// Assumes both ends share the core clock domain.
`timescale 1ns/10ps
interface aad_alu_if;
    aad_pkg::aad_op_t op;
    logic [7:0]       a;
    logic [7:0]       b;
    logic [7:0]       res;
    logic             carry;
    logic             digit_carry;
    logic             zero;

    modport ctrl (output op, output a, output b,
                  input res, input carry, input digit_carry, input zero);
    modport alu  (input op, input a, input b,
                  output res, output carry, output digit_carry, output zero);
endinterface

// *** core/aad_alu.sv ***
// Combinational add/AND unit with carry, digit carry and zero outputs.
// Assumes operands are stable for the whole cycle.
`timescale 1ns/10ps
module aad_alu (
    // ALU side of the carrier
    aad_alu_if.alu alu
);
    logic [8:0] sum_w;
    logic [4:0] low_w;
    logic       is_add_w;

    // Full and low-nibble sums; the nibble sum gives the digit carry
    assign sum_w    = {1'b0, alu.a} + {1'b0, alu.b};
    assign low_w    = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
    assign is_add_w = (alu.op == aad_pkg::AAD_OP_ADD_REG) || (alu.op == aad_pkg::AAD_OP_ADD_IMM);

    // Result select and flag sources
    assign alu.res         = is_add_w ? sum_w[7:0] : (alu.a & alu.b);
    assign alu.carry       = sum_w[aad_pkg::CARRY_BIT];
    assign alu.digit_carry = low_w[aad_pkg::DIGIT_BIT];
    assign alu.zero        = (alu.res == 8'h00);
endmodule // aad_alu

// *** testbench/aad_datapath_tb.sv ***
// Self-checking bench for the accumulator add/AND datapath.
// Assumes the bench acts as decoder and as a zero-latency register file.
`timescale 1ns/10ps
module aad_datapath_tb;
    // Decoder side
    logic             clk_sys_i;
    logic             srst_i;
    logic             op_valid_i;
    aad_pkg::aad_op_t opcode_i;
    logic [7:0]       imm_i;
    logic [5:0]       reg_addr_i;
    logic             dest_i;
    // Register file side and state
    logic [5:0]       rf_raddr_o;
    logic             rf_we_o;
    logic [5:0]       rf_waddr_o;
    logic [7:0]       rf_wdata_o;
    logic [7:0]       accumulator_o;
    logic             carry_flag_o;
    logic             digit_carry_flag_o;
    logic             zero_flag_o;
    logic [7:0]       mem [64];
    logic [25:0]      exp_r;
    int               miscompares;
    int               tests_run;
    // Packed view: acc, C, DC, Z, write pulse, write address, write data
    wire logic [25:0] got = {accumulator_o, carry_flag_o, digit_carry_flag_o,
                             zero_flag_o, rf_we_o, rf_waddr_o, rf_wdata_o};
    wire logic [7:0]  rf_rdata_i = mem[rf_raddr_o];

    aad_datapath u_aad_datapath (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .op_valid_i(op_valid_i),
        .opcode_i(opcode_i), .imm_i(imm_i), .reg_addr_i(reg_addr_i),
        .dest_i(dest_i), .rf_raddr_o(rf_raddr_o), .rf_rdata_i(rf_rdata_i),
        .rf_we_o(rf_we_o), .rf_waddr_o(rf_waddr_o), .rf_wdata_o(rf_wdata_o),
        .accumulator_o(accumulator_o), .carry_flag_o(carry_flag_o),
        .digit_carry_flag_o(digit_carry_flag_o), .zero_flag_o(zero_flag_o)
    );

    // 100 ns clock
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // Register file without forwarding, so a read right after a write sees old data
    always @(posedge clk_sys_i) begin
        if (rf_we_o) mem[rf_waddr_o] <= rf_wdata_o;
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Drives one op at this edge, checks the previous op, then predicts this one
    task automatic op(input logic v, input aad_pkg::aad_op_t oc, input logic [7:0] im,
                      input logic [5:0] ad, input logic d, input logic rs);
        logic [7:0] b;
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] r;
        srst_i     <= rs;
        op_valid_i <= v;
        opcode_i   <= oc;
        imm_i      <= im;
        reg_addr_i <= ad;
        dest_i     <= d;
        @(negedge clk_sys_i);
        tests_run++;
        if (got !== exp_r) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp_r);
        end
        b = oc[0] ? im : mem[ad];
        s = {1'b0, exp_r[25:18]} + {1'b0, b};
        n = {1'b0, exp_r[21:18]} + {1'b0, b[3:0]};
        r = oc[1] ? (exp_r[25:18] & b) : s[7:0];
        exp_r[14] = 1'b0;
        if (rs) exp_r = 26'h0000000;
        else if (v) begin
            if (!oc[1]) exp_r[17:16] = {s[8], n[4]};
            exp_r[15] = (r == 8'h00);
            if (!oc[0] && d) exp_r[14:0] = {1'b1, ad, r};
            else exp_r[25:18] = r;
        end
        @(posedge clk_sys_i);
    endtask

    // Immediate adds at the operand bounds, with a wrap to zero
    task automatic t_add_imm();
        op(1'b1, aad_pkg::AAD_OP_ADD_IMM, 8'hFF, 6'h00, 1'b1, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_ADD_IMM, 8'h01, 6'h00, 1'b0, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_ADD_IMM, 8'h00, 6'h00, 1'b0, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_ADD_IMM, 8'h0F, 6'h00, 1'b0, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_ADD_IMM, 8'h01, 6'h00, 1'b0, 1'b0);
        op(1'b0, aad_pkg::AAD_OP_ADD_IMM, 8'h00, 6'h00, 1'b0, 1'b0);
    endtask

    // Register adds to both destinations, back to back, then a read-back
    task automatic t_add_reg();
        op(1'b1, aad_pkg::AAD_OP_ADD_REG, 8'h00, 6'h00, 1'b0, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_ADD_REG, 8'h00, 6'h3F, 1'b1, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_ADD_REG, 8'h00, 6'h05, 1'b1, 1'b0);
        op(1'b0, aad_pkg::AAD_OP_ADD_REG, 8'h00, 6'h3F, 1'b1, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_ADD_REG, 8'h00, 6'h3F, 1'b0, 1'b0);
        op(1'b0, aad_pkg::AAD_OP_ADD_REG, 8'h00, 6'h00, 1'b0, 1'b0);
    endtask

    // AND ops leave carry and digit carry as the last add set them
    task automatic t_and_ops();
        op(1'b1, aad_pkg::AAD_OP_ADD_IMM, 8'hF9, 6'h00, 1'b0, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_AND_REG, 8'h00, 6'h0A, 1'b0, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_AND_REG, 8'h00, 6'h14, 1'b1, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_AND_IMM, 8'hFF, 6'h00, 1'b1, 1'b0);
        op(1'b1, aad_pkg::AAD_OP_AND_IMM, 8'h00, 6'h00, 1'b0, 1'b0);
        op(1'b0, aad_pkg::AAD_OP_AND_IMM, 8'h00, 6'h00, 1'b0, 1'b0);
    endtask

    // Reset in mid-run wins over a valid op
    task automatic t_reset();
        op(1'b1, aad_pkg::AAD_OP_ADD_IMM, 8'h5A, 6'h00, 1'b0, 1'b1);
        op(1'b1, aad_pkg::AAD_OP_ADD_IMM, 8'h88, 6'h00, 1'b0, 1'b0);
        op(1'b0, aad_pkg::AAD_OP_ADD_IMM, 8'h88, 6'h00, 1'b0, 1'b0);
    endtask

    // Main sequence; the first check sees the reset state
    initial begin
        srst_i = 1'b1;
        op_valid_i = 1'b0;
        opcode_i = aad_pkg::AAD_OP_ADD_REG;
        imm_i = 8'h00;
        reg_addr_i = 6'h00;
        dest_i = 1'b0;
        exp_r = 26'h0000000;
        miscompares = 0;
        tests_run = 0;
        for (int i = 0; i < 64; i++) mem[i] = 8'(i * 29 + 53);
        repeat (4) @(posedge clk_sys_i);
        t_add_imm();
        t_add_reg();
        t_and_ops();
        t_reset();
        print_verdict();
    end

    // Watchdog, about twelve times the expected run
    initial begin
        #30000;
        miscompares++;
        print_verdict();
    end
endmodule // aad_datapath_tb
